// >>> core/sdm_drive_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_drive_ctrl
    import sdm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wr_stb,
    input wire logic [7:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [7:0] rd_addr,
    output logic [15:0] rd_data,
    output logic wr_ack,
    input wire logic [15:0] pot_speed,
    input wire logic enable_pin_n,
    input wire logic dir_pin_n,
    input wire logic brake_pin_n,
    output logic motor_run,
    output logic motor_reverse,
    output logic motor_brake,
    output logic [15:0] speed_cmd,
    output logic [1:0] mode_state
);
    logic [15:0] ctrl_reg;
    logic [15:0] speed_reg;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [15:0] pot_s1_reg;
    logic [15:0] pot_s2_reg;
    logic [15:0] pot_s3_reg;
    logic [15:0] pot_word_reg;
    // Named idle levels, stop speed and the value of a read that hits no register.
    localparam logic [2:0] SDM_PIN_IDLE = 3'h7;
    localparam logic [15:0] SDM_READ_UNMAPPED = 16'h0000;
    localparam logic [15:0] SDM_SPEED_STOP = 16'h0000;
    localparam logic [15:0] SDM_POT_RESET = 16'h0000;
    localparam logic [1:0] SDM_STATE_RESET = 2'h0;

    // Mode decode is used for both state and outputs, so it lives in a function.
    function automatic sdm_mode_t mode_of(input logic [15:0] v);
        case (v[SDM_MODE_HI:SDM_MODE_LO])
            SDM_MODE_ANALOG: mode_of = SDM_ANALOG_SPEED_MODE;
            SDM_MODE_DIGITAL: mode_of = SDM_DIGITAL_SPEED_MODE;
            SDM_MODE_POSITION: mode_of = SDM_POSITION_HOLD_MODE;
            default: mode_of = SDM_MODE_UNKNOWN;
        endcase
    endfunction

    // Register decode and the control fields.
    // field decode.
    wire sdm_mode_t cur_mode = mode_of(ctrl_reg);
    wire ctrl_en = ctrl_reg[SDM_EN_BIT];
    wire ctrl_rev = ctrl_reg[SDM_REV_BIT];
    wire hit_ctrl = wr_stb && (wr_addr == SDM_ADDR_CTRL);
    wire hit_speed = wr_stb && (wr_addr == SDM_ADDR_SPEED);
    wire is_analog = (cur_mode == SDM_ANALOG_SPEED_MODE);
    wire is_digital = (cur_mode == SDM_DIGITAL_SPEED_MODE);
    // Synchronised pins are active low; bit 0 enable, 1 direction, 2 brake.
    wire pin_en = ~pin_s2_reg[0];
    wire pin_rev = ~pin_s2_reg[1];
    wire pin_brake = ~pin_s2_reg[2];
    wire [15:0] rd_next = (rd_addr == SDM_ADDR_CTRL) ? ctrl_reg :
        (rd_addr == SDM_ADDR_SPEED) ? speed_reg : SDM_READ_UNMAPPED;
    // Two synchronised samples of the pot word that agree mean it was not caught mid-change.
    wire pot_agree = (pot_s2_reg == pot_s3_reg);

    // Motor commands; the brake wins over everything so a locked motor never turns.
    // analog enable pin, register enable.
    wire run_next = !pin_brake && ctrl_en &&
        ((is_analog && pin_en) || is_digital);
    wire rev_next = is_analog ? pin_rev : (is_digital && ctrl_rev);
    wire [15:0] speed_next = !run_next ? SDM_SPEED_STOP :
        is_analog ? pot_word_reg : speed_reg;

    // Register file: single-register writes take effect the cycle they arrive.
    // control write.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg <= SDM_CTRL_RESET;
            speed_reg <= SDM_SPEED_RESET;
            wr_ack <= 1'b0;
            rd_data <= SDM_READ_UNMAPPED;
        end else if (clk_en) begin
            if (hit_ctrl) begin
                ctrl_reg <= wr_data;
            end
            if (hit_speed) begin
                speed_reg <= wr_data;
            end
            wr_ack <= wr_stb;
            rd_data <= rd_next;
        end
    end

    // Pins and potentiometer word come from outside, so two stages before use.
    // Pins reset to their idle high level so that no false press follows reset.
    // A third pot stage lets the word be compared with the one before it.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_s1_reg <= SDM_PIN_IDLE;
            pin_s2_reg <= SDM_PIN_IDLE;
            pot_s1_reg <= SDM_POT_RESET;
            pot_s2_reg <= SDM_POT_RESET;
            pot_s3_reg <= SDM_POT_RESET;
        end else if (clk_en) begin
            pin_s1_reg <= {brake_pin_n, dir_pin_n, enable_pin_n};
            pin_s2_reg <= pin_s1_reg;
            pot_s1_reg <= pot_speed;
            pot_s2_reg <= pot_s1_reg;
            pot_s3_reg <= pot_s2_reg;
        end
    end

    // The word is only taken once two samples agree, which costs one cycle of latency.
    // settled pot word.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pot_word_reg <= SDM_POT_RESET;
        end else if (clk_en && pot_agree) begin
            pot_word_reg <= pot_s3_reg;
        end
    end

    // Output stage, all registered.
    // brake hold.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            motor_run <= 1'b0;
            motor_reverse <= 1'b0;
            motor_brake <= 1'b0;
            speed_cmd <= SDM_SPEED_STOP;
            mode_state <= SDM_STATE_RESET;
        end else if (clk_en) begin
            motor_run <= run_next;
            motor_reverse <= rev_next;
            motor_brake <= pin_brake;
            speed_cmd <= speed_next;
            mode_state <= cur_mode;
        end
    end

    // write of 0000 disables the motor.
    a_stop_on_zero: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && hit_ctrl && wr_data == 16'h0000 ##1 clk_en |=> !motor_run)
        else $error("motor ran after stop write");
    a_analog_pin_en: assert property (@(posedge clock) disable iff (!rst_n)
        motor_run && $past(is_analog) |-> $past(pin_en))
        else $error("analog run without enable pin");
    a_brake_locks: assert property (@(posedge clock) disable iff (!rst_n)
        motor_brake |-> !motor_run && speed_cmd == 16'h0000)
        else $error("motor turned while braked");
    a_digital_speed: assert property (@(posedge clock) disable iff (!rst_n)
        motor_run && $past(is_digital) |-> speed_cmd == $past(speed_reg))
        else $error("digital speed not from register");
    a_analog_speed: assert property (@(posedge clock) disable iff (!rst_n)
        motor_run && $past(is_analog) |-> speed_cmd == $past(pot_word_reg))
        else $error("analog speed not from pot");
    a_digital_rev: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && $past(is_digital) && $past(clk_en) |-> motor_reverse == $past(ctrl_rev))
        else $error("digital direction wrong");
    a_analog_rev: assert property (@(posedge clock) disable iff (!rst_n)
        $past(is_analog) && $past(clk_en) |-> motor_reverse == $past(pin_rev))
        else $error("analog direction wrong");
    // digital enable write runs the motor unless braked.
    a_digital_run: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && hit_ctrl && wr_data == 16'h0101 ##1 clk_en && !pin_brake
        |=> motor_run)
        else $error("0101 did not run motor");
    a_mode_decode: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) |-> mode_state == $past(mode_of(ctrl_reg)))
        else $error("mode state mismatch");

    // The checks below guard the register port, the freeze, the mode gating, the brake output and the pot filter.
    // They look at the state and outputs that this block drives and at its port inputs.

    a_ack_follows_write: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && wr_stb |=> wr_ack)
        else $error("write not acknowledged");

    a_ack_only_write: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && wr_ack |-> $past(wr_stb))
        else $error("ack without write");

    a_ctrl_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && hit_ctrl |=> ctrl_reg == $past(wr_data))
        else $error("control write lost");

    a_speed_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && hit_speed |=> speed_reg == $past(wr_data))
        else $error("speed write lost");

    // a low enable freezes the motor outputs.
    a_freeze_holds: assert property (@(posedge clock) disable iff (!rst_n)
        !clk_en |=> $stable(motor_run) && $stable(speed_cmd) && $stable(ctrl_reg))
        else $error("state moved while frozen");

    // a low enable freezes the register port.
    a_freeze_bus: assert property (@(posedge clock) disable iff (!rst_n)
        !clk_en |=> $stable(wr_ack) && $stable(rd_data))
        else $error("port moved while frozen");

    a_no_run_other: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && !$past(is_analog) && !$past(is_digital) |-> !motor_run)
        else $error("motor ran in other mode");

    a_stop_speed_zero: assert property (@(posedge clock) disable iff (!rst_n)
        !motor_run |-> speed_cmd == SDM_SPEED_STOP)
        else $error("speed while stopped");

    // digital run ignores the enable pin.
    a_digital_ignores_pin: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(is_digital) && $past(ctrl_en) && !$past(pin_brake) |-> motor_run)
        else $error("digital enable did not run");

    // digital stop when bit 0 is clear.
    a_digital_stop: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(is_digital) && !$past(ctrl_en) |-> !motor_run)
        else $error("digital ran without enable");

    a_analog_needs_bit: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(is_analog) && !$past(ctrl_en) |-> !motor_run)
        else $error("analog ran without enable bit");

    // analog runs with bit and pin.
    a_analog_run_full: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(is_analog) && $past(ctrl_en) && $past(pin_en) &&
        !$past(pin_brake) |-> motor_run)
        else $error("analog enable did not run");

    // analog stops when the pin is released.
    a_analog_pin_off: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(is_analog) && !$past(pin_en) |-> !motor_run)
        else $error("analog ran with pin released");

    a_brake_follows_pin: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) |-> motor_brake == $past(pin_brake))
        else $error("brake output wrong");

    a_read_ctrl: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(rd_addr) == SDM_ADDR_CTRL |-> rd_data == $past(ctrl_reg))
        else $error("control read wrong");

    a_read_speed: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(rd_addr) == SDM_ADDR_SPEED |-> rd_data == $past(speed_reg))
        else $error("speed read wrong");

    a_read_unmapped: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(rd_addr) != SDM_ADDR_CTRL && $past(rd_addr) != SDM_ADDR_SPEED
        |-> rd_data == SDM_READ_UNMAPPED)
        else $error("unmapped read not zero");

    a_unmapped_write_keeps: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && wr_stb && !hit_ctrl |=> $stable(ctrl_reg))
        else $error("control changed by other write");

    a_speed_keeps: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !hit_speed |=> $stable(speed_reg))
        else $error("speed changed without write");

    a_pot_filter: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(pot_s2_reg) != $past(pot_s3_reg) |-> $stable(pot_word_reg))
        else $error("unsettled pot word taken");

    a_mode_digital_state: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(ctrl_reg[SDM_MODE_HI:SDM_MODE_LO]) == SDM_MODE_DIGITAL
        |-> mode_state == SDM_DIGITAL_SPEED_MODE)
        else $error("digital mode not decoded");

    a_mode_analog_state: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(ctrl_reg[SDM_MODE_HI:SDM_MODE_LO]) == SDM_MODE_ANALOG
        |-> mode_state == SDM_ANALOG_SPEED_MODE)
        else $error("analog mode not decoded");

    a_position_state: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clk_en) && $past(ctrl_reg[SDM_MODE_HI:SDM_MODE_LO]) == SDM_MODE_POSITION
        |-> mode_state == SDM_POSITION_HOLD_MODE && !motor_run)
        else $error("position mode wrong");
endmodule
`default_nettype wire

// >>> core/sdm_pkg.sv
package sdm_pkg;
    // Register addresses on the register-access port.
    localparam logic [7:0] SDM_ADDR_CTRL = 8'h02;
    localparam logic [7:0] SDM_ADDR_SPEED = 8'h0E;
    // Field positions of the control register.
    localparam int SDM_MODE_HI = 15;
    localparam int SDM_MODE_LO = 8;
    localparam int SDM_EN_BIT = 0;
    localparam int SDM_REV_BIT = 3;
    // Mode numbers carried in the upper byte.
    localparam logic [7:0] SDM_MODE_ANALOG = 8'h00;
    localparam logic [7:0] SDM_MODE_DIGITAL = 8'h01;
    localparam logic [7:0] SDM_MODE_POSITION = 8'h02;
    // Reset values and speed limit.
    localparam logic [15:0] SDM_CTRL_RESET = 16'h0000;
    localparam logic [15:0] SDM_SPEED_RESET = 16'h0000;
    localparam logic [15:0] SDM_SPEED_MAX = 16'h4650;
    typedef enum logic [1:0] {
        SDM_ANALOG_SPEED_MODE,
        SDM_DIGITAL_SPEED_MODE,
        SDM_POSITION_HOLD_MODE,
        SDM_MODE_UNKNOWN
    } sdm_mode_t;
endpackage

// >>> dv/sdm_drive_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_drive_ctrl_bench;
    import sdm_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, wr_stb, wr_ack, ok, en_n = 1'b1, dir_n = 1'b1, brk_n = 1'b1;
    logic [7:0] wr_addr, rd_addr = 8'h00;
    logic [15:0] wr_data, rd_data, speed_cmd, pot = 16'h0000, ctrl = 16'h0000, spd = 16'h0000;
    logic motor_run, motor_reverse, motor_brake;
    logic ce = 1'b1;
    logic [1:0] mode_state;
    logic [21:0] note_q[$];
    logic [15:0] seq[6] = '{16'h0100, 16'h0101, 16'h0109, 16'h0000, 16'h0201, 16'h0501};
    int error_cnt = 0, tests_run = 0, seed = 32'h5666;
    event chk;
    always #12.5 clock = ~clock;
    sdm_host sdm_host_inst (.clock(clock), .wr_ack(wr_ack), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data));
    sdm_drive_ctrl sdm_drive_ctrl_inst (.clock(clock), .rst_n(rst_n), .clk_en(ce),
        .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_ack(wr_ack), .pot_speed(pot), .enable_pin_n(en_n),
        .dir_pin_n(dir_n), .brake_pin_n(brk_n), .motor_run(motor_run),
        .motor_reverse(motor_reverse), .motor_brake(motor_brake), .speed_cmd(speed_cmd),
        .mode_state(mode_state));
    task automatic bad(input string s);
        error_cnt++;
        $display("Error at %0t: %s", $time, s);
    endtask
    task automatic cmp_out(input logic [20:0] e);
        tests_run++;
        // Direction is only defined while the motor turns, so it is skipped otherwise.
        if ({motor_run, motor_brake, mode_state, speed_cmd} !== {e[20], e[18:0]} ||
            (e[20] && motor_reverse !== e[19])) bad("motor outputs differ");
    endtask
    task automatic cmp_rd(input logic [15:0] e);
        tests_run++;
        if (rd_data !== e) bad("read data differs");
    endtask
    // Oldest note is taken and compared each time a result is announced.
    always @(chk) begin : watch
        logic [21:0] e;
        e = note_q.pop_front();
        if (e[21]) cmp_rd(e[15:0]);
        else cmp_out(e[20:0]);
    end
    task automatic step();
        logic [7:0] m;
        logic an, run;
        m = ctrl[15:8];
        an = (m == SDM_MODE_ANALOG);
        run = ctrl[SDM_EN_BIT] && brk_n && (an ? !en_n : m == SDM_MODE_DIGITAL);
        note_q.push_back({1'b0, run, an ? !dir_n : ctrl[SDM_REV_BIT], !brk_n,
            m > 8'h02 ? 2'h3 : m[1:0], run ? (an ? pot : spd) : 16'h0000});
        repeat (4) @(posedge clock);
        #1 -> chk;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        sdm_host_inst.put(a, d, ok);
        if (!ok) bad("no write ack");
        if (a == SDM_ADDR_CTRL) ctrl = d;
        if (a == SDM_ADDR_SPEED) spd = d;
        step();
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        #1 rd_addr = a;
        note_q.push_back({1'b1, 5'h00, e});
        repeat (2) @(posedge clock);
        #1 -> chk;
    endtask
    task automatic test_done();
        $display("Checks run %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog cuts a hang short well past the expected run length.
    initial begin
        #60000;
        bad("watchdog expired");
        test_done();
    end
    // Main sequence: analog pins first, then control codes for each mode.
    initial begin
        repeat (4) @(posedge clock);
        #1 rst_n = 1'b1;
        wr(SDM_ADDR_CTRL, 16'h0000);
        pot = 16'($random(seed));
        en_n = 1'b0;
        wr(SDM_ADDR_CTRL, 16'h0001);
        dir_n = 1'b0;
        step();
        brk_n = 1'b0;
        step();
        brk_n = 1'b1;
        en_n = 1'b1;
        step();
        wr(SDM_ADDR_SPEED, 16'($unsigned($random(seed)) % 16'h4651));
        foreach (seq[i]) wr(SDM_ADDR_CTRL, seq[i]);
        wr(SDM_ADDR_CTRL, 16'h0101);
        // A brake press while the enable is low must not show until the enable returns.
        ce = 1'b0;
        fork
            step();
            #2 brk_n = 1'b0;
        join
        ce = 1'b1;
        step();
        brk_n = 1'b1;
        wr(8'h05, 16'hFFFF);
        rd(SDM_ADDR_CTRL, 16'h0101);
        rd(SDM_ADDR_SPEED, spd);
        rd(8'h05, 16'h0000);
        test_done();
    end
endmodule
`default_nettype wire

// >>> dv/sdm_host.sv
`timescale 1ns/1ps
`default_nettype none
// Register-access host that issues single-register writes.
module sdm_host (
    input wire logic clock,
    input wire logic wr_ack,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [15:0] wr_data
);
    initial begin
        wr_stb = 1'b0;
        wr_addr = 8'h00;
        wr_data = 16'h0000;
    end
    // wait for response
    // Each write is a one-cycle strobe; the next write waits until the ack has been seen or 8 cycles have passed.
    task automatic put(input logic [7:0] a, input logic [15:0] d, output logic ok);
        int n;
        @(posedge clock);
        #1 wr_stb = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge clock);
        #1 wr_stb = 1'b0;
        wr_addr = ~a; // Released lines carry junk so that stale values never look valid.
        wr_data = ~d;
        n = 0;
        while (wr_ack !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1 n++;
        end
        ok = (wr_ack === 1'b1);
    endtask
endmodule
`default_nettype wire
